// [shared/arpf_cfg.svh]
// Constants of the asynchronous receive packet formatter
`ifndef ARPF_CFG_SVH
`define ARPF_CFG_SVH
`define ARPF_ACK_COMPLETE   4'h1
`define ARPF_ACK_PENDING    4'h2
`define ARPF_ACK_BUSY_X     4'h4
`define ARPF_ACK_BUSY_A     4'h5
`define ARPF_ACK_BUSY_B     4'h6
`define ARPF_ACK_DATA_ERR   4'hd
`define ARPF_ACK_TYPE_ERR   4'he
`define ARPF_TC_WR_QUAD     4'h0
`define ARPF_TC_WR_BLK      4'h1
`define ARPF_TC_WR_RESP     4'h2
`define ARPF_TC_RD_BLK      4'h5
`define ARPF_TC_RD_QRESP    4'h6
`define ARPF_TC_RD_BRESP    4'h7
`define ARPF_TC_RD_QUAD     4'h4
`define ARPF_TC_LOCK_REQ    4'h9
`define ARPF_TC_STREAM      4'ha
`define ARPF_TC_LOCK_RESP   4'hb
`define ARPF_SYNTH_HDR      32'h0000_00e0
`define ARPF_TCODE_LSB      4
`define ARPF_LEN_LSB        16
`define ARPF_STAT_SPD_LSB   4
`define ARPF_ASYNC_HDR_Q    14'h0004
`define ARPF_STREAM_HDR_Q   14'h0001
`define ARPF_LEN_IDX_ASYNC  14'h0003
`define ARPF_FIFO_DEPTH     8
`define ARPF_RDY_LEVEL      4'h5
`endif

// [shared/arpf_pkg.sv]
// Types of the asynchronous receive packet formatter
`default_nettype none
package arpf_pkg;
    typedef struct packed {
        logic [31:0] data;
        logic        sop;
        logic        eop;
        logic        isPhy;
        logic        badAlign;
        logic        overrun;
        logic        crcErr;
        logic        typeErr;
        logic [1:0]  busy;
        logic        extValid;
        logic [3:0]  extAck;
        logic [1:0]  speed;
    } arpf_lnk_t;
    typedef struct packed {
        logic        toResp;
        logic        last;
        logic [31:0] data;
    } arpf_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BODY = 3'b001,
        ST_PHYW = 3'b010,
        ST_SID  = 3'b011,
        ST_HOLD = 3'b100,
        ST_STAT = 3'b101
    } arpf_state_t;
endpackage
`default_nettype wire

// [design/arpf_formatter.sv]
// Receive packet formatter with its output FIFO
// Summary of operation
// - Accepted packet, or completed request, gets acknowledge code 0001.
// - Accepted request awaiting response gets 0010; never for responses.
// - Busy refusals report 0100 plain, 0101 phase A, 0110 phase B.
// - Block data CRC failure or payload length mismatch reports 1101.
// - Data error never reported for packets without block payload.
// - Unsupported or invalid request header or transaction reports 1110.
// - Reserved codes never generated; a received one passes through unchanged except in stream records.
// - No-data record: header, source ID with offset or rcode, then status.
// - Quadlet write request and read response data is fourth quadlet.
// - Block read request fourth quadlet holds length, reserved low half.
// - Block fourth quadlet holds length and extended code, zero unless lock.
// - Block payload follows the length quadlet; status quadlet ends record.
// - Stream record: length/tag/channel quadlet, payload, speed and status.
// - Asynchronous stream records always go to the response FIFO.
// - Self-ID and PHY records start with synthesized header, tcode 0xE.
// - Self-ID quadlets from reset end are concatenated until a cycle with selfIdWin low and no quadlet taken.
// - Self-ID inverted check quadlets kept unverified; host checks them.
// - Self-ID status: data error on misalignment or overrun, else complete.
// - PHY record holds exactly one quadlet after the header.
// - PHY check quadlet is verified here and not stored.
// - First payload byte sits in the top byte of first quadlet.
// - Partial final payload quadlet is padded with zero bytes.
// - Stream status is 0001 when good, 1101 on CRC or size error.
`default_nettype none
`include "arpf_cfg.svh"

// ----------------------------------------
// Output FIFO
// ----------------------------------------
module arpf_fifo
    import arpf_pkg::*;
#(
    parameter int W = 34,
    parameter int D = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     inValid,
    input  wire logic [W-1:0]             inData,
    output logic                          inReady,
    output logic                          outValid,
    output logic [W-1:0]                  outData,
    input  wire logic                     outReady,
    output logic [$clog2(D+1)-1:0]        level
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic          doWr;
    logic          doRd;

    assign inReady  = count != CW'(D);
    assign outValid = count != '0;
    assign outData  = mem[rdPtr];
    assign level    = count;
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= bump(wrPtr);
            end
            if (doRd) begin
                rdPtr <= bump(rdPtr);
            end
            count <= count + CW'(doWr) - CW'(doRd);
        end
    end
endmodule

// ----------------------------------------
// Formatter
// ----------------------------------------
module arpf_formatter
    import arpf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       lnkValid,
    input  wire arpf_lnk_t  lnkIn,
    input  wire logic       selfIdWin,
    output logic            rxReady,
    output logic            rxfValid,
    output arpf_word_t      rxfWord,
    input  wire logic       rxfReady
);

    // ----------------------------------------
    // Transaction code decode
    // ----------------------------------------
    function automatic logic isResp(input logic [3:0] t);
        return t == `ARPF_TC_WR_RESP || t == `ARPF_TC_RD_QRESP
            || t == `ARPF_TC_RD_BRESP || t == `ARPF_TC_LOCK_RESP;
    endfunction

    function automatic logic hasBlock(input logic [3:0] t);
        return t == `ARPF_TC_WR_BLK || t == `ARPF_TC_RD_BRESP
            || t == `ARPF_TC_LOCK_REQ || t == `ARPF_TC_LOCK_RESP
            || t == `ARPF_TC_STREAM;
    endfunction

    function automatic logic needsPend(input logic [3:0] t);
        return t == `ARPF_TC_RD_QUAD || t == `ARPF_TC_RD_BLK
            || t == `ARPF_TC_LOCK_REQ;
    endfunction

    function automatic logic [13:0] quadsOf(input logic [15:0] len);
        return 14'((len + 16'h0003) >> 2);
    endfunction

    function automatic logic [31:0] padMask(input logic [1:0] lo);
        unique case (lo)
            2'h1:    return 32'hff00_0000;
            2'h2:    return 32'hffff_0000;
            2'h3:    return 32'hffff_ff00;
            default: return 32'hffff_ffff;
        endcase
    endfunction

    // Priority: passed-through code, type, data, busy, then success
    function automatic logic [3:0] ackOf(input arpf_lnk_t q,
                                         input logic [3:0] t,
                                         input logic lenBad);
        if (q.extValid)
            return q.extAck;
        if (q.typeErr && !isResp(t))
            return `ARPF_ACK_TYPE_ERR;
        if (hasBlock(t) && (q.crcErr || lenBad))
            return `ARPF_ACK_DATA_ERR;
        if (q.busy == 2'h1)
            return `ARPF_ACK_BUSY_X;
        if (q.busy == 2'h2)
            return `ARPF_ACK_BUSY_A;
        if (q.busy == 2'h3)
            return `ARPF_ACK_BUSY_B;
        if (!isResp(t) && needsPend(t))
            return `ARPF_ACK_PENDING;
        return `ARPF_ACK_COMPLETE;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    arpf_state_t st;
    arpf_state_t next_st;
    arpf_state_t holdRet;
    arpf_state_t next_holdRet;
    logic [3:0]  tcode;
    logic [13:0] idx;
    logic [15:0] lenReg;
    logic [31:0] hold;
    logic [31:0] next_hold;
    logic        holdLast;
    logic        next_holdLast;
    logic        sidErr;
    logic [31:0] statWord;
    logic        statResp;
    logic        statBlk;
    logic        statExt;
    logic        statStream;
    logic        next_rxReady;

    // ----------------------------------------
    // Current quadlet decode
    // ----------------------------------------
    logic        accept;
    logic        inPkt;
    logic [3:0]  curT;
    logic [13:0] curIdx;
    logic        isStream;
    logic [13:0] hdrQ;
    logic [13:0] lenIdx;
    logic [15:0] curLen;
    logic        isPay;
    logic [13:0] payIdx;
    logic        lastPay;
    logic [31:0] shaped;
    logic [13:0] rcvQ;
    logic        lenBad;
    logic        dataBad;
    logic [3:0]  streamStat;
    logic [3:0]  pktAck;
    logic [31:0] pktStat;
    logic        toRespPkt;
    logic        phyOk;
    logic        sidBadNow;
    logic [7:0]  fifoLevel;
    logic [3:0]  fifoLevel4;
    logic        fifoInReady;

    assign accept   = lnkValid && rxReady;
    assign inPkt    = (st == ST_IDLE && !selfIdWin && !lnkIn.isPhy) || st == ST_BODY;
    assign curT     = (st == ST_IDLE) ? lnkIn.data[`ARPF_TCODE_LSB +: 4] : tcode;
    assign curIdx   = (st == ST_IDLE) ? 14'h0000 : idx;
    assign isStream = curT == `ARPF_TC_STREAM;
    assign hdrQ     = isStream ? `ARPF_STREAM_HDR_Q : `ARPF_ASYNC_HDR_Q;
    assign lenIdx   = isStream ? 14'h0000 : `ARPF_LEN_IDX_ASYNC;
    assign curLen   = (curIdx == lenIdx) ? lnkIn.data[`ARPF_LEN_LSB +: 16] : lenReg;
    assign isPay    = hasBlock(curT) && curIdx >= hdrQ;
    assign payIdx   = curIdx - hdrQ;
    assign lastPay  = isPay && payIdx == quadsOf(lenReg) - 14'h0001;

    // Length quadlet keeps the length; low half reserved or extended code
    always_comb begin
        shaped = lnkIn.data;
        if (curIdx == `ARPF_LEN_IDX_ASYNC && !isStream) begin
            if (curT == `ARPF_TC_RD_BLK) begin
                shaped[15:0] = 16'h0000;
            end else if (curT == `ARPF_TC_WR_BLK || curT == `ARPF_TC_RD_BRESP) begin
                shaped[15:0] = 16'h0000;
            end
        end
        if (lastPay) begin
            shaped = lnkIn.data & padMask(lenReg[1:0]);
        end
    end

    // Quadlets actually seen against the count that the length promises
    assign rcvQ    = (curIdx + 14'h0001 >= hdrQ) ? curIdx + 14'h0001 - hdrQ : 14'h0000;
    assign lenBad  = hasBlock(curT) && rcvQ != quadsOf(curLen);
    assign dataBad = lnkIn.crcErr || lenBad;
    assign streamStat = dataBad ? `ARPF_ACK_DATA_ERR : `ARPF_ACK_COMPLETE;
    assign pktAck  = ackOf(lnkIn, curT, lenBad);
    assign pktStat = {26'h0, lnkIn.speed, isStream ? streamStat : pktAck};
    assign toRespPkt = isResp(curT) || isStream;
    assign phyOk     = lnkIn.data == ~hold;
    assign sidBadNow = lnkIn.badAlign || lnkIn.overrun;
    assign fifoLevel4 = fifoLevel[3:0];

    // ----------------------------------------
    // Next state and FIFO write
    // ----------------------------------------
    logic       wrValid;
    arpf_word_t wrWord;

    always_comb begin
        next_st       = st;
        next_holdRet  = holdRet;
        next_hold     = hold;
        next_holdLast = holdLast;
        wrValid       = 1'b0;
        wrWord        = '{toResp: 1'b0, last: 1'b0, data: 32'h0};
        unique case (st)
            ST_IDLE, ST_BODY: begin
                if (accept && st == ST_IDLE && selfIdWin) begin
                    wrValid       = 1'b1;
                    wrWord.data   = `ARPF_SYNTH_HDR;
                    next_hold     = lnkIn.data;
                    next_holdLast = 1'b0;
                    next_holdRet  = ST_SID;
                    next_st       = ST_HOLD;
                end else if (accept && st == ST_IDLE && lnkIn.isPhy) begin
                    next_hold = lnkIn.data;
                    next_st   = ST_PHYW;
                end else if (accept) begin
                    wrValid       = 1'b1;
                    wrWord.toResp = toRespPkt;
                    wrWord.data   = shaped;
                    next_st       = lnkIn.eop ? ST_STAT : ST_BODY;
                end
            end
            ST_PHYW: begin
                if (accept) begin
                    next_st = ST_IDLE;
                    if (phyOk) begin
                        wrValid       = 1'b1;
                        wrWord.data   = `ARPF_SYNTH_HDR;
                        next_holdLast = 1'b1;
                        next_holdRet  = ST_IDLE;
                        next_st       = ST_HOLD;
                    end
                end
            end
            ST_SID: begin
                if (accept) begin
                    wrValid     = 1'b1;
                    wrWord.data = lnkIn.data;
                end else if (!selfIdWin) begin
                    next_st = ST_STAT;
                end
            end
            ST_HOLD: begin
                wrValid     = 1'b1;
                wrWord.last = holdLast;
                wrWord.data = hold;
                next_st     = holdRet;
            end
            ST_STAT: begin
                wrValid       = 1'b1;
                wrWord.last   = 1'b1;
                wrWord.toResp = statResp;
                wrWord.data   = statWord;
                next_st       = ST_IDLE;
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    // Ready only in taking states; three free words cover lag and trailer
    assign next_rxReady = (next_st == ST_IDLE || next_st == ST_BODY
        || next_st == ST_PHYW || next_st == ST_SID) && fifoLevel4 <= `ARPF_RDY_LEVEL;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st       <= ST_IDLE;
            holdRet  <= ST_IDLE;
            hold     <= 32'h0;
            holdLast <= 1'b0;
            rxReady  <= 1'b0;
        end else begin
            st       <= next_st;
            holdRet  <= next_holdRet;
            hold     <= next_hold;
            holdLast <= next_holdLast;
            rxReady  <= next_rxReady;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tcode  <= 4'h0;
            idx    <= 14'h0;
            lenReg <= 16'h0;
        end else if (accept && inPkt) begin
            tcode  <= curT;
            idx    <= curIdx + 14'h0001;
            lenReg <= curLen;
        end
    end

    // Record status, taken with the closing quadlet, or for self-ID when the window closes
    always_ff @(posedge clk) begin
        if (rst) begin
            statWord   <= 32'h0;
            statResp   <= 1'b0;
            statBlk    <= 1'b0;
            statExt    <= 1'b0;
            statStream <= 1'b0;
        end else if (accept && inPkt && lnkIn.eop) begin
            statWord   <= pktStat;
            statResp   <= toRespPkt;
            statBlk    <= hasBlock(curT);
            statExt    <= lnkIn.extValid;
            statStream <= isStream;
        end else if (st == ST_SID && !accept && !selfIdWin) begin
            statWord   <= {28'h0, sidErr ? `ARPF_ACK_DATA_ERR : `ARPF_ACK_COMPLETE};
            statResp   <= 1'b0;
            statBlk    <= 1'b1;
            statExt    <= 1'b0;
            statStream <= 1'b0;
        end
    end

    // Sticky misalignment or overrun across the self-ID string
    always_ff @(posedge clk) begin
        if (rst) begin
            sidErr <= 1'b0;
        end else if (accept && st == ST_IDLE && selfIdWin) begin
            sidErr <= sidBadNow;
        end else if (accept && st == ST_SID) begin
            sidErr <= sidErr || sidBadNow;
        end
    end

    // ----------------------------------------
    // Output FIFO
    // ----------------------------------------
    logic [$bits(arpf_word_t)-1:0] fifoOut;

    arpf_fifo #(
        .W($bits(arpf_word_t)),
        .D(`ARPF_FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .rst     (rst),
        .inValid (wrValid),
        .inData  (wrWord),
        .inReady (fifoInReady),
        .outValid(rxfValid),
        .outData (fifoOut),
        .outReady(rxfReady),
        .level   (fifoLevel[3:0])
    );

    assign fifoLevel[7:4] = 4'h0;
    assign rxfWord = arpf_word_t'(fifoOut);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_pend_resp: assert property (
        @(posedge clk) disable iff (rst)
        st == ST_STAT && statResp && !statStream && !statExt
        |-> wrWord.data[3:0] != `ARPF_ACK_PENDING)
        else $error("pending code on a response");

    chk_no_data_err: assert property (
        @(posedge clk) disable iff (rst)
        st == ST_STAT && !statBlk && !statExt
        |-> wrWord.data[3:0] != `ARPF_ACK_DATA_ERR)
        else $error("data error on a packet without payload");

    chk_sid_header: assert property (
        @(posedge clk) disable iff (rst)
        accept && st == ST_IDLE && selfIdWin
        |-> wrValid && wrWord.data == `ARPF_SYNTH_HDR
            ##1 st == ST_HOLD && wrValid ##1 st == ST_SID)
        else $error("self-ID header not synthesized");

    chk_phy_one_quad: assert property (
        @(posedge clk) disable iff (rst)
        st == ST_PHYW && accept && phyOk
        |-> wrValid ##1 (wrValid && wrWord.last) ##1 (st == ST_IDLE && !wrWord.last))
        else $error("PHY record is not header plus one quadlet");

    chk_phy_bad_drop: assert property (
        @(posedge clk) disable iff (rst)
        st == ST_PHYW && accept && !phyOk |-> !wrValid ##1 st == ST_IDLE)
        else $error("PHY packet with bad check was stored");

    chk_stream_fifo: assert property (
        @(posedge clk) disable iff (rst)
        wrValid && (st == ST_BODY || st == ST_IDLE) && inPkt && isStream
        |-> wrWord.toResp)
        else $error("stream routed to request FIFO");

    chk_eop_status: assert property (
        @(posedge clk) disable iff (rst)
        accept && inPkt && lnkIn.eop
        |=> st == ST_STAT && wrValid && wrWord.last && !rxReady)
        else $error("status quadlet missing after packet end");

    chk_ext_pass: assert property (
        @(posedge clk) disable iff (rst)
        accept && inPkt && lnkIn.eop && lnkIn.extValid && !isStream
        |=> wrWord.data[3:0] == $past(lnkIn.extAck))
        else $error("received acknowledge code altered");

    chk_pad_zero: assert property (
        @(posedge clk) disable iff (rst)
        accept && inPkt && lastPay
        |-> (wrWord.data & ~padMask(lenReg[1:0])) == 32'h0)
        else $error("pad bytes not zero");

    chk_fifo_room: assert property (
        @(posedge clk) disable iff (rst)
        wrValid |-> fifoInReady)
        else $error("write into a full FIFO");

endmodule
`default_nettype wire

// [tb/arpf_link_model.sv]
// Link core model that hands received quadlets to the formatter
`default_nettype none
module arpf_link_model
    import arpf_pkg::*;
(
    input  wire logic clk,
    input  wire logic rxReady,
    output logic      lnkValid,
    output arpf_lnk_t lnkIn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        lnkValid = 1'b0;
        lnkIn = '0;
    end
    // Word stands until taken or for at most 500 more cycles, then the task moves on
    task automatic put(input arpf_lnk_t w);
        lnkValid <= 1'b1;
        lnkIn <= w;
        @(posedge clk);
        for (int i = 0; i < 500 && rxReady !== 1'b1; i++) @(posedge clk);
    endtask
    // Released bus shows inverted data, so a stale word never looks valid
    task automatic idle();
        lnkValid <= 1'b0;
        lnkIn.data <= ~lnkIn.data;
    endtask
endmodule
`default_nettype wire

// [tb/arpf_formatter_bench.sv]
// Self-checking bench of the receive packet formatter
`default_nettype none
module arpf_formatter_bench
    import arpf_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] Q1 = 32'hffc1_ffff;
    localparam logic [31:0] Q2 = 32'hf000_0400;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       selfIdWin = 1'b0;
    logic       rxfReady = 1'b1;
    logic       lnkValid;
    logic       rxReady;
    logic       rxfValid;
    arpf_lnk_t  lnkIn;
    arpf_word_t rxfWord;
    arpf_word_t got[$];
    arpf_word_t exp[$];
    int         failures = 0;
    int         comparisons = 0;
    always #10 clk = ~clk;
    arpf_formatter uut (.clk(clk), .rst(rst), .lnkValid(lnkValid), .lnkIn(lnkIn),
        .selfIdWin(selfIdWin), .rxReady(rxReady), .rxfValid(rxfValid),
        .rxfWord(rxfWord), .rxfReady(rxfReady));
    arpf_link_model link (.clk(clk), .rxReady(rxReady), .lnkValid(lnkValid), .lnkIn(lnkIn));
    always @(posedge clk) if (rxfValid === 1'b1 && rxfReady === 1'b1) got.push_back(rxfWord);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] h0(input logic [3:0] tc);
        return {16'hffc0, 8'h14, tc, 4'h0};
    endfunction
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic post(input logic [31:0] hdr[$], input int nPay, input arpf_lnk_t tail,
                        input logic resp, input logic [3:0] ack);
        logic [31:0] q[$];
        arpf_lnk_t   w;
        q = hdr;
        for (int i = 0; i < nPay; i++) q.push_back(32'h0102_0300 + 32'(i));
        @(posedge clk);
        foreach (q[i]) begin
            w = (i == q.size() - 1) ? tail : '0;
            w.data = q[i];
            w.sop = (i == 0);
            w.eop = (i == q.size() - 1);
            link.put(w);
            exp.push_back({resp, 1'b0, q[i]});
        end
        link.idle();
        exp.push_back({resp, 1'b1, 26'h0, tail.speed, ack});
    endtask
    task automatic drain(input string name);
        for (int i = 0; i < 300 && got.size() < exp.size(); i++) @(posedge clk);
        repeat (10) @(posedge clk);
        check("words", 34'(got.size()), 34'(exp.size()));
        foreach (exp[i]) if (i < got.size()) check(name, got[i], exp[i]);
        got.delete();
        exp.delete();
        $display("test %s done", name);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_acks();
        arpf_lnk_t t;
        t = '0;
        t.speed = 2'h2;
        post('{h0(4'h0), Q1, Q2, 32'ha1b2_c3d4}, 0, t, 1'b0, 4'h1);
        post('{h0(4'h2), Q1, Q2}, 0, t, 1'b1, 4'h1);
        post('{h0(4'h4), Q1, Q2}, 0, t, 1'b0, 4'h2);
        post('{h0(4'h5), Q1, Q2, 32'h0010_0009}, 0, t, 1'b0, 4'h2);
        exp[exp.size() - 2].data = 32'h0010_0000;
        post('{h0(4'h6), Q1, Q2, 32'h5566_7788}, 0, t, 1'b1, 4'h1);
        post('{h0(4'h9), Q1, Q2, 32'h0008_0002}, 2, t, 1'b0, 4'h2);
        post('{h0(4'h1), Q1, Q2, 32'h0006_0005}, 2, t, 1'b0, 4'h1);
        exp[exp.size() - 4].data = 32'h0006_0000;
        exp[exp.size() - 2].data = 32'h0102_0000;
        t.crcErr = 1'b1;
        post('{h0(4'h0), Q1, Q2, 32'h0}, 0, t, 1'b0, 4'h1);
        post('{h0(4'h1), Q1, Q2, 32'h0008_0000}, 2, t, 1'b0, 4'hd);
        t.crcErr = 1'b0;
        post('{h0(4'h1), Q1, Q2, 32'h0008_0000}, 1, t, 1'b0, 4'hd);
        t.typeErr = 1'b1;
        post('{h0(4'h0), Q1, Q2, 32'h0}, 0, t, 1'b0, 4'he);
        t.extValid = 1'b1;
        t.extAck = 4'h3;
        post('{h0(4'h0), Q1, Q2, 32'h0}, 0, t, 1'b0, 4'h3);
        t = '0;
        for (int b = 1; b < 4; b++) begin
            t.busy = 2'(b);
            post('{h0(4'h0), Q1, Q2, 32'h0}, 0, t, 1'b0, 4'(b + 3));
        end
        drain("acks");
    endtask
    task automatic t_stream();
        arpf_lnk_t t;
        t = '0;
        t.speed = 2'h1;
        post('{32'h0008_41a0}, 2, t, 1'b1, 4'h1);
        post('{32'h0000_41a0}, 0, t, 1'b1, 4'h1);
        t.crcErr = 1'b1;
        post('{32'h0004_41a0}, 1, t, 1'b1, 4'hd);
        drain("stream");
    endtask
    task automatic phy(input logic [31:0] d, input logic [31:0] chk);
        arpf_lnk_t w;
        @(posedge clk);
        w = '0;
        w.data = d;
        w.sop = 1'b1;
        w.isPhy = 1'b1;
        link.put(w);
        w = '0;
        w.data = chk;
        w.eop = 1'b1;
        link.put(w);
        link.idle();
    endtask
    task automatic t_phy();
        phy(32'h4123_4567, ~32'h4123_4567);
        exp.push_back({2'b00, 32'h0000_00e0});
        exp.push_back({2'b01, 32'h4123_4567});
        phy(32'h4123_4567, 32'h4123_4567);
        drain("phy");
    endtask
    task automatic sid(input logic ovr, input logic [3:0] ack);
        arpf_lnk_t   w;
        logic [31:0] d[4] = '{32'h8041_2c01, 32'h7fbe_d3fe, 32'h8141_2c00, 32'h7ebe_d3ff};
        repeat (3) @(posedge clk);
        selfIdWin <= 1'b1;
        exp.push_back({2'b00, 32'h0000_00e0});
        foreach (d[i]) begin
            w = '0;
            w.data = d[i];
            w.sop = (i == 0);
            w.overrun = ovr && i == 3;
            link.put(w);
            exp.push_back({2'b00, d[i]});
        end
        link.idle();
        selfIdWin <= 1'b0;
        exp.push_back({2'b01, 28'h0, ack});
    endtask
    task automatic t_sid();
        sid(1'b0, 4'h1);
        sid(1'b1, 4'hd);
        drain("selfid");
    endtask
    // Host stalls so the link must be held off before the FIFO overflows
    task automatic t_fill();
        arpf_lnk_t t;
        t = '0;
        rxfReady <= 1'b0;
        fork
            begin
                post('{h0(4'h0), Q1, Q2, 32'h1111_2222}, 0, t, 1'b0, 4'h1);
                post('{h0(4'h0), Q1, Q2, 32'h3333_4444}, 0, t, 1'b0, 4'h1);
            end
            begin
                repeat (40) @(posedge clk);
                check("stall", {32'h0, rxReady, rxfValid}, 34'h1);
                rxfReady <= 1'b1;
            end
        join
        drain("fill");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_acks();
        t_stream();
        t_phy();
        t_sid();
        t_fill();
        report_and_stop();
    end
    // Whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
